// >>> src/efflt_core.sv
// Purpose: receive frame filter with rate meter and alarm trap
// Assumes: one byte per clock, whole frame held until verdict at last byte
// Notes:   frames are buffered in FRAME_MAX bytes; longer frames are cut
`timescale 1ns/1ps
`default_nettype none
`include "efflt_map.svh"
module efflt_core
  import efflt_pkg::*;
#(
  parameter int          ROWS      = `EFFLT_ROWS,
  parameter int          LEVELS    = `EFFLT_LEVELS,
  parameter int          FRAME_MAX = 256,
  parameter logic [31:0] GATE_CYC  = 32'(`EFFLT_GATE_CYC)
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_resetn,
  // Received byte stream
  input  wire logic          i_rx_valid,
  input  wire logic [7:0]    i_rx_data,
  input  wire logic          i_rx_last,
  input  wire logic          i_rx_err,
  // Configuration
  input  wire logic          i_filt_on,
  input  wire efflt_row_t    i_row [ROWS],
  input  wire efflt_lvl_t    i_vlan_lvl [LEVELS],
  input  wire efflt_lvl_t    i_mpls_lvl [LEVELS],
  input  wire efflt_struct_t i_struct,
  input  wire logic [7:0]    i_pat_ofs,
  input  wire logic [2:0]    i_encap_allow,  // Ethertype, SNAP, LLC
  input  wire logic          i_fast_rate,
  input  wire logic [63:0]   i_ref_bps,
  input  wire logic          i_trap_clr,
  // Passed frames
  output logic               o_tx_valid,
  output logic [7:0]         o_tx_data,
  output logic               o_tx_last,
  input  wire logic          i_tx_ready,
  // Status
  output logic [63:0]        o_rate_bps,
  output logic [63:0]        o_diff_bps,
  output logic [31:0]        o_diff_ppm,
  output efflt_alarm_t       o_alarm_now,
  output efflt_alarm_t       o_alarm_trap,
  output logic               o_frame_pass,
  output logic               o_frame_drop
);
  typedef enum logic [1:0] {ST_RECV, ST_SEND} efflt_st_t;
  efflt_st_t   st_q;
  logic [7:0]  buf_q [FRAME_MAX];
  logic [15:0] cnt_q, len_q, rd_q;
  logic [47:0] dst_q, src_q;
  logic [31:0] pat_q;
  logic [15:0] type_q;
  logic [7:0]  dsap_q;
  logic [31:0] tag_q [LEVELS];
  logic [3:0]  ntag_q;
  logic        mpls_q, tagdone_q;
  logic [31:0] shw_q;
  logic        verdict;
  logic [ROWS-1:0] hit;
  logic        encap_ok;
  logic        acc;
  logic        sk_ready, sk_valid;
  logic [8:0]  sk_data;
  logic        push_ok;

  // Masked equality on one field
  function automatic logic meq(input logic [47:0] v, input logic [47:0] m,
                               input logic [47:0] f);
    return ((v ^ f) & m) == 48'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Header capture while the frame is written into the buffer
  assign acc = i_rx_valid && (st_q == ST_RECV);
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 16'h0;
      dst_q <= 48'h0;
      src_q <= 48'h0;
      type_q <= 16'h0;
      dsap_q <= 8'h0;
      pat_q <= 32'h0;
      shw_q <= 32'h0;
      ntag_q <= 4'h0;
      mpls_q <= 1'b0;
      tagdone_q <= 1'b0;
      for (int i = 0; i < LEVELS; i++) tag_q[i] <= 32'h0;
    end else if (acc) begin
      cnt_q <= i_rx_last ? 16'h0 : cnt_q + 16'h1;
      shw_q <= {shw_q[23:0], i_rx_data};
      if (cnt_q < 16'd6) dst_q <= {dst_q[39:0], i_rx_data};
      else if (cnt_q < 16'd12) src_q <= {src_q[39:0], i_rx_data};
      // Pattern word ends three bytes after the offset byte
      if (cnt_q == {8'h0, i_pat_ofs} + 16'd3)
        pat_q <= {shw_q[23:0], i_rx_data};
      // Tag walk: 4-byte VLAN tags or MPLS labels after the type field
      if (cnt_q == 16'd13) begin
        type_q <= {shw_q[7:0], i_rx_data};
        mpls_q <= ({shw_q[7:0], i_rx_data} == `EFFLT_ETYPE_MPLS);
        tagdone_q <= ({shw_q[7:0], i_rx_data} != `EFFLT_ETYPE_VLAN) &&
                     ({shw_q[7:0], i_rx_data} != `EFFLT_ETYPE_MPLS);
        ntag_q <= 4'h0;
      end
      if (cnt_q == 16'd14) dsap_q <= i_rx_data;
      if (cnt_q >= 16'd17 && cnt_q[1:0] == 2'd1 && !tagdone_q &&
          ntag_q < 4'(LEVELS)) begin
        tag_q[ntag_q[2:0]] <= {shw_q[23:0], i_rx_data};
        ntag_q <= ntag_q + 4'h1;
        // MPLS stops at bottom of stack, VLAN when next type is not a tag
        tagdone_q <= mpls_q ? shw_q[0] :  // S is bit 8 of the label word
                     ({shw_q[7:0], i_rx_data} != `EFFLT_ETYPE_VLAN);
      end
      if (i_rx_last) tagdone_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict: encapsulation stage then filter bank
  always_comb begin
    logic is_eth;
    logic is_snap;
    is_eth  = type_q >= `EFFLT_ETYPE_MIN;
    is_snap = !is_eth && dsap_q == `EFFLT_SNAP_DSAP;
    encap_ok = (i_encap_allow == 3'b000) ||
               (i_encap_allow[0] && is_eth) || (i_encap_allow[1] && is_snap) ||
               (i_encap_allow[2] && !is_eth && !is_snap);
    for (int r = 0; r < ROWS; r++) begin
      logic ok;
      ok = i_row[r].en && !(i_fast_rate && r >= `EFFLT_ROWS_FAST);
      ok = ok && meq(i_row[r].dst_val, i_row[r].dst_msk, dst_q);
      ok = ok && meq(i_row[r].src_val, i_row[r].src_msk, src_q);
      if (i_struct.has_pat)
        ok = ok && meq({16'h0, i_row[r].pat_val}, {16'h0, i_row[r].pat_msk},
                       {16'h0, pat_q});
      for (int l = 0; l < LEVELS; l++) begin
        if (i_struct.has_vlan && !mpls_q && i_row[r].vlan_use[l])
          ok = ok && (4'(l) < ntag_q) &&
               meq({32'h0, i_vlan_lvl[l].val[15:0]}, {32'h0, i_vlan_lvl[l].msk[15:0]},
                   {32'h0, tag_q[l][31:16]});
        if (i_struct.has_mpls && mpls_q && i_row[r].mpls_use[l])
          ok = ok && (4'(l) < ntag_q) &&
               meq({16'h0, i_mpls_lvl[l].val}, {16'h0, i_mpls_lvl[l].msk},
                   {16'h0, tag_q[l]});
      end
      hit[r] = ok;
    end
    verdict = encap_ok && (!i_filt_on || (|hit));
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame store and replay of passed frames
  assign push_ok = (st_q == ST_SEND) && sk_ready;
  // Frame bytes into the store; kept out of reset so it maps onto plain memory
  always_ff @(posedge i_core_clk) begin
    if (acc && cnt_q < 16'(FRAME_MAX)) buf_q[cnt_q[$clog2(FRAME_MAX)-1:0]] <= i_rx_data;
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_RECV;
      len_q <= 16'h0;
      rd_q <= 16'h0;
      o_frame_pass <= 1'b0;
      o_frame_drop <= 1'b0;
    end else begin
      o_frame_pass <= 1'b0;
      o_frame_drop <= 1'b0;
      unique case (st_q)
        ST_RECV: begin
          if (acc && i_rx_last) begin
            len_q <= (cnt_q < 16'(FRAME_MAX)) ? cnt_q : 16'(FRAME_MAX - 1);
            rd_q <= 16'h0;
            if (verdict && !i_rx_err && cnt_q >= 16'd13) begin
              st_q <= ST_SEND;
              o_frame_pass <= 1'b1;
            end else begin
              o_frame_drop <= 1'b1;
            end
          end
        end
        ST_SEND: begin
          if (push_ok) begin
            rd_q <= rd_q + 16'h1;
            if (rd_q == len_q) st_q <= ST_RECV;
          end
        end
      endcase
    end
  end

  efflt_skid #(.W(9)) u_skid (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_valid    (push_ok),
    .i_data     ({buf_q[rd_q[$clog2(FRAME_MAX)-1:0]], rd_q == len_q}),
    .o_ready    (sk_ready),
    .o_valid    (sk_valid),
    .o_data     (sk_data),
    .i_ready    (!o_tx_valid)
  );

  // Output register fed from the buffer; loads whenever empty, so a stall only holds it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h0;
      o_tx_last <= 1'b0;
    end else if (o_tx_valid) begin
      if (i_tx_ready) o_tx_valid <= 1'b0;
    end else if (sk_valid) begin
      o_tx_valid <= 1'b1;
      {o_tx_data, o_tx_last} <= sk_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate meter: bits counted over a fixed gate, scaled to bps
  logic [31:0]        gate_q;
  logic [63:0]        bits_q;
  logic [63:0]        bits_d;
  logic [63:0]        rate_d;
  logic signed [63:0] diff_d;
  // Closing cycle counts too, so a gate spans exactly GATE_CYC byte slots
  always_comb begin
    bits_d = bits_q + (i_rx_valid ? 64'd8 : 64'd0);
    rate_d = bits_d * (64'd1000000000 / 64'(`EFFLT_GATE_NS));
    diff_d = $signed(rate_d) - $signed(i_ref_bps);
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_q <= 32'h0;
      bits_q <= 64'h0;
      o_rate_bps <= 64'h0;
      o_diff_bps <= 64'h0;
      o_diff_ppm <= 32'h0;
    end else begin
      bits_q <= bits_d;
      gate_q <= gate_q + 32'h1;
      if (gate_q == GATE_CYC - 32'h1) begin
        gate_q <= 32'h0;
        bits_q <= 64'h0;
        o_rate_bps <= rate_d;
        o_diff_bps <= diff_d;
        // Signed division keeps a slow line negative in ppm
        o_diff_ppm <= (i_ref_bps == 64'h0) ? 32'h0 :
          32'((diff_d * 64'sd1000000) / $signed(i_ref_bps));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarms: current per frame and latched trap, set beats clear
  efflt_alarm_t now;
  always_comb begin
    now.runt  = acc && i_rx_last && cnt_q < 16'd13;
    now.abort = acc && i_rx_err;
    now.drop  = i_rx_valid && (st_q != ST_RECV);
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_now  <= '0;
      o_alarm_trap <= '0;
    end else begin
      o_alarm_now  <= now;
      o_alarm_trap <= (i_trap_clr ? '0 : o_alarm_trap) | now;
    end
  end
endmodule
`default_nettype wire

// >>> src/efflt_map.svh
// Purpose: constants of the receive frame filter
// Assumes: byte stream, one byte per clock
// Notes:   included by the package and by efflt_core
`ifndef EFFLT_MAP_SVH
`define EFFLT_MAP_SVH
`define EFFLT_ROWS          8
`define EFFLT_ROWS_FAST     4
`define EFFLT_LEVELS        8
`define EFFLT_MAC_DST_POS   0
`define EFFLT_MAC_SRC_POS   6
`define EFFLT_TYPE_POS      12
`define EFFLT_TAG_POS       14
`define EFFLT_ETYPE_MIN     16'h0600
`define EFFLT_ETYPE_VLAN    16'h8100
`define EFFLT_ETYPE_MPLS    16'h8847
`define EFFLT_SNAP_DSAP     8'haa
`define EFFLT_CLK_HZ        200000000
`define EFFLT_GATE_NS       1000000
`define EFFLT_GATE_CYC      ((`EFFLT_GATE_NS * 64'd200) / 64'd1000)
`endif

// >>> src/efflt_pkg.sv
// Purpose: types of the receive frame filter
// Assumes: nothing
// Notes:   constants live in efflt_map.svh
`include "efflt_map.svh"
package efflt_pkg;
  // One filter row: value and mask of address and pattern fields, per-level tag enables
  typedef struct packed {
    logic        en;
    logic [47:0] dst_val;
    logic [47:0] dst_msk;
    logic [47:0] src_val;
    logic [47:0] src_msk;
    logic [31:0] pat_val;
    logic [31:0] pat_msk;
    logic [7:0]  vlan_use;   // Per level enable
    logic [7:0]  mpls_use;
  } efflt_row_t;
  // One tag level: value and mask of the 32-bit word (VLAN uses low 16)
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] msk;
  } efflt_lvl_t;
  // Field presence of the configured frame structure
  typedef struct packed {
    logic has_vlan;
    logic has_mpls;
    logic has_pat;
  } efflt_struct_t;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } efflt_beat_t;
  // Alarm vector: frame too short, bad framing, overflow
  typedef struct packed {
    logic runt;
    logic abort;
    logic drop;
  } efflt_alarm_t;
endpackage

// >>> src/efflt_skid.sv
// Purpose: two-entry buffer in the passed-byte path
// Assumes: one clock, active-low asynchronous reset
// Notes:   ready depends only on occupancy, so a stall loses no word
`timescale 1ns/1ps
`default_nettype none
module efflt_skid #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  logic [W-1:0] mem_q [2];
  logic         rd_q, wr_q;
  logic [1:0]   cnt_q;
  logic         push, pop;

  assign push    = i_valid && (cnt_q != 2'd2);
  assign pop     = i_ready && (cnt_q != 2'd0);
  assign o_ready = (cnt_q != 2'd2);
  assign o_valid = (cnt_q != 2'd0);
  assign o_data  = mem_q[rd_q];

  // Storage and pointers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= i_data;
        wr_q        <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// >>> tb/efflt_core_asserts.sv
// Purpose: port checks of efflt_core
// Assumes: one clock, active-low reset
// Notes:   attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module efflt_chk
  import efflt_pkg::*;
(
  // Clock, reset, inputs
  input wire logic         i_core_clk,
  input wire logic         i_resetn,
  input wire logic         i_rx_valid,
  input wire logic         i_rx_last,
  input wire logic         i_trap_clr,
  input wire logic         i_tx_ready,
  // Outputs watched
  input wire logic         o_tx_valid,
  input wire logic [7:0]   o_tx_data,
  input wire logic         o_tx_last,
  input wire efflt_alarm_t o_alarm_now,
  input wire efflt_alarm_t o_alarm_trap,
  input wire logic         o_frame_pass,
  input wire logic         o_frame_drop
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////
  AST_ONE_VERDICT: assert property (!(o_frame_pass && o_frame_drop))
    else $error("pass and drop together");
  AST_VERDICT_AFTER_LAST: assert property ((o_frame_pass || o_frame_drop)
    |-> $past(i_rx_valid && i_rx_last)) else $error("verdict without last byte");
  AST_TRAP_STICKY: assert property (!i_trap_clr
    |=> (o_alarm_trap & $past(o_alarm_trap)) == $past(o_alarm_trap))
    else $error("trap bit lost");
  AST_TRAP_CLEARS: assert property ((i_trap_clr && o_alarm_now == 3'h0)[*3]
    |-> o_alarm_trap == 3'h0) else $error("trap not cleared");
  AST_NOW_TO_TRAP: assert property (o_alarm_now.runt |-> ##[0:1] o_alarm_trap.runt)
    else $error("alarm not trapped");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready
    |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last)) else $error("tx not held");
  AST_TX_GAP: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid)
    else $error("tx valid without gap");
  AST_PASS_TO_TX: assert property (o_frame_pass |-> ##[1:6] o_tx_valid)
    else $error("passed frame not sent");
  // Main scenarios
  cover property (o_frame_pass);
  cover property (o_frame_drop);
  cover property (o_alarm_trap.runt);
endmodule
bind efflt_core efflt_chk u_chk (.i_core_clk, .i_resetn, .i_rx_valid, .i_rx_last,
  .i_trap_clr, .i_tx_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .o_alarm_now,
  .o_alarm_trap, .o_frame_pass, .o_frame_drop);
`default_nettype wire

// >>> tb/efflt_src.sv
// Purpose: remote transmitter feeding the receive stream
// Assumes: one byte per clock while a frame is sent
// Notes:   data line toggles between frames
`timescale 1ns/1ps
`default_nettype none
module efflt_src (
  // Clock
  input  wire logic  i_core_clk,
  // Received stream
  output logic       o_valid,
  output logic [7:0] o_data,
  output logic       o_last,
  output logic       o_err
);
  logic [7:0] mem [256];
  initial begin
    o_valid = 1'b0;
    o_data  = 8'h5a;
    o_last  = 1'b0;
    o_err   = 1'b0;
  end
  // Sends mem[0..n-1], err marks the final byte
  task automatic send(input int n, input logic err);
    for (int i = 0; i < n; i++) begin
      @(negedge i_core_clk);
      o_valid = 1'b1;
      o_data  = mem[i];
      o_last  = (i == n - 1);
      o_err   = err && (i == n - 1);
    end
    @(negedge i_core_clk);
    o_valid = 1'b0;
    o_last  = 1'b0;
    o_err   = 1'b0;
    o_data  = ~o_data;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench of efflt_core
// Assumes: short rate gate of 100 cycles
// Notes:   verdicts and bytes checked from queues
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import efflt_pkg::*;
  logic          i_core_clk, i_resetn, i_rx_valid, i_rx_last, i_rx_err, i_tx_ready;
  logic          i_filt_on, i_fast_rate, i_trap_clr, o_tx_valid, o_tx_last;
  logic          o_frame_pass, o_frame_drop;
  logic [7:0]    i_rx_data, i_pat_ofs, o_tx_data;
  logic [2:0]    i_encap_allow;
  logic [63:0]   i_ref_bps, o_rate_bps, o_diff_bps;
  logic [31:0]   o_diff_ppm;
  efflt_row_t    i_row [8];
  efflt_lvl_t    i_vlan_lvl [8];
  efflt_lvl_t    i_mpls_lvl [8];
  efflt_struct_t i_struct;
  efflt_alarm_t  o_alarm_now, o_alarm_trap;
  int            n_errors, n_checks, seed;
  logic          vq [$];
  logic [8:0]    bq [$];
  efflt_core #(.GATE_CYC(32'h64)) u_dut (.i_core_clk, .i_resetn, .i_rx_valid, .i_rx_data,
    .i_rx_last, .i_rx_err, .i_filt_on, .i_row, .i_vlan_lvl, .i_mpls_lvl, .i_struct,
    .i_pat_ofs, .i_encap_allow, .i_fast_rate, .i_ref_bps, .i_trap_clr, .o_tx_valid,
    .o_tx_data, .o_tx_last, .i_tx_ready, .o_rate_bps, .o_diff_bps, .o_diff_ppm,
    .o_alarm_now, .o_alarm_trap, .o_frame_pass, .o_frame_drop);
  efflt_src u_src (.i_core_clk, .o_valid(i_rx_valid), .o_data(i_rx_data),
    .o_last(i_rx_last), .o_err(i_rx_err));
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Fills a frame of class 0 Ethertype, 1 SNAP, 2 LLC
  task automatic mk(input int n, input int c);
    for (int i = 0; i < n; i++) u_src.mem[i] = 8'($random(seed));
    u_src.mem[12] = (c == 0) ? 8'h08 : 8'h00;
    u_src.mem[13] = 8'h20;
    u_src.mem[14] = (c == 1) ? 8'haa : 8'h42;
  endtask
  // Notes the outcome, sends, waits until all is seen
  task automatic go(input int n, input logic err, input logic pass);
    vq.push_back(pass);
    if (pass) for (int i = 0; i < n; i++) bq.push_back({i == n - 1, u_src.mem[i]});
    u_src.send(n, err);
    for (int t = 0; t < 3000 && (vq.size() || bq.size()); t++) @(negedge i_core_clk);
    repeat (4) @(negedge i_core_clk);
  endtask
  function automatic logic [31:0] pw(input int o);
    return {u_src.mem[o], u_src.mem[o+1], u_src.mem[o+2], u_src.mem[o+3]};
  endfunction
  task automatic prow(input int r, input logic en, input logic [31:0] v, input logic [31:0] m);
    i_row[r] = '0;
    i_row[r].en = en;
    i_row[r].pat_val = v;
    i_row[r].pat_msk = m;
  endtask
  // Frame with a tag stack: type, then two 4-byte tag words
  task automatic tagf(input logic [15:0] ty, input logic [31:0] w0, input logic [31:0] w1);
    mk(32, 0);
    {u_src.mem[12], u_src.mem[13]} = ty;
    {u_src.mem[14], u_src.mem[15], u_src.mem[16], u_src.mem[17]} = w0;
    {u_src.mem[18], u_src.mem[19], u_src.mem[20], u_src.mem[21]} = w1;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock and random stall of the receiver
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  always @(negedge i_core_clk) i_tx_ready <= 1'($random(seed));
  // Result watcher
  always @(posedge i_core_clk) begin
    if (o_frame_pass || o_frame_drop)
      chk("verdict", vq.size() ? vq.pop_front() : 'x, o_frame_pass);
    if (o_tx_valid && i_tx_ready)
      chk("tx byte", bq.size() ? bq.pop_front() : 'x, {o_tx_last, o_tx_data});
  end
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 79014;
    i_resetn = 1'b0;
    i_filt_on = 1'b0;
    i_fast_rate = 1'b0;
    i_trap_clr = 1'b0;
    i_pat_ofs = 8'h07;
    i_encap_allow = 3'h0;
    i_ref_bps = 64'haae60;
    i_struct = 3'h1;
    i_vlan_lvl = '{default: '0};
    i_mpls_lvl = '{default: '0};
    foreach (i_row[r]) i_row[r] = '0;
    repeat (3) @(negedge i_core_clk);
    i_resetn = 1'b1;
    for (int c = 0; c < 3; c++) begin
      mk(40, c);
      go(40, 1'b0, 1'b1);
    end
    for (int a = 0; a < 3; a++) begin
      i_encap_allow = 3'h1 << a;
      for (int c = 0; c < 3; c++) begin
        mk(20, c);
        go(20, 1'b0, a == c);
      end
    end
    i_encap_allow = 3'h0;
    mk(10, 0);
    go(10, 1'b0, 1'b0);
    chk("runt trap", 64'h1, o_alarm_trap.runt);
    mk(30, 0);
    go(30, 1'b1, 1'b0);
    chk("abort trap", 64'h1, o_alarm_trap.abort);
    i_trap_clr = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_trap_clr = 1'b0;
    chk("trap clear", 64'h0, o_alarm_trap);
    // Pattern rows on one stored frame
    i_filt_on = 1'b1;
    mk(32, 0);
    prow(0, 1'b1, pw(7), 32'hffffffff);
    go(32, 1'b0, 1'b1);
    prow(0, 1'b1, pw(7) ^ 32'h1, 32'hffffffff);
    go(32, 1'b0, 1'b0);
    prow(0, 1'b1, pw(7) ^ 32'h1, 32'hfffffffe);
    go(32, 1'b0, 1'b1);
    prow(0, 1'b1, pw(7) ^ 32'h1, 32'hffffffff);
    prow(1, 1'b0, pw(7), 32'hffffffff);
    go(32, 1'b0, 1'b0);
    prow(5, 1'b1, pw(7), 32'hffffffff);
    i_fast_rate = 1'b1;
    go(32, 1'b0, 1'b0);
    i_fast_rate = 1'b0;
    go(32, 1'b0, 1'b1);
    prow(5, 1'b0, 32'h0, 32'h0);
    i_struct = 3'h0;
    go(32, 1'b0, 1'b1);
    i_struct = 3'h1;
    i_pat_ofs = 8'h00;
    prow(0, 1'b1, pw(0), 32'hffffffff);
    go(32, 1'b0, 1'b1);
    // Tag stacks: VLAN on level 0, MPLS on level 1 behind a non-bottom label
    i_struct = 3'h4;
    tagf(16'h8100, 32'h61230800, 32'h0);
    prow(0, 1'b1, 32'h0, 32'h0);
    i_row[0].vlan_use = 8'h01;
    i_vlan_lvl[0] = '{val: 32'h00006123, msk: 32'h0000ffff};
    go(32, 1'b0, 1'b1);
    i_vlan_lvl[0].val = 32'h00006122;
    go(32, 1'b0, 1'b0);
    i_struct = 3'h2;
    tagf(16'h8847, 32'h01234041, 32'h05678141);
    i_row[0].vlan_use = 8'h00;
    i_row[0].mpls_use = 8'h02;
    i_mpls_lvl[1] = '{val: 32'h05678141, msk: 32'hffffffff};
    go(32, 1'b0, 1'b1);
    i_mpls_lvl[1].val = 32'h05678140;
    go(32, 1'b0, 1'b0);
    // Full-rate traffic spanning whole gates
    mk(250, 0);
    fork
      go(250, 1'b1, 1'b0);
      begin
        repeat (230) @(negedge i_core_clk);
        chk("rate", 64'hc3500, o_rate_bps);
        chk("diff bps", 64'h186a0, o_diff_bps);
        chk("diff ppm", 64'h22e09, o_diff_ppm);
      end
    join
    tally_and_finish();
  end
endmodule
`default_nettype wire
